// >>> design/fmrc_pkg.sv
// constants shared by the flash mode and reset control block
package fmrc_pkg;
    localparam logic [7:0] OP_RELEASE = 8'hFF;
    localparam logic [7:0] OP_QPI_ON = 8'h38;
    localparam logic [7:0] OP_DUAL_READ = 8'hBB;
    localparam logic [7:0] OP_QUAD_READ = 8'hEB;
    localparam logic [7:0] OP_RESET_ARM = 8'h66;
    localparam logic [7:0] OP_RESET = 8'h99;
    localparam logic [7:0] OP_NO_OPERATION = 8'h00;

    // continuation field of the read mode byte and the code that keeps the read going
    localparam int CONT_FIELD_LSB = 4;
    localparam logic [1:0] CONT_CODE = 2'h2;

    localparam int EDGE_W = 5;
    localparam logic [EDGE_W-1:0] EDGE_MAX = 5'h1F;
    localparam logic [EDGE_W-1:0] OPC_EDGES_SPI = 5'h08;
    localparam logic [EDGE_W-1:0] OPC_EDGES_QPI = 5'h02;

    // where the read mode byte sits in a frame, counted in link clock edges
    localparam int NUM_CAND = 5;
    localparam int CAND_DUAL_SPI = 0;
    localparam int CAND_DUAL_CONT = 1;
    localparam int CAND_QUAD_SPI = 2;
    localparam int CAND_QUAD_CONT = 3;
    localparam int CAND_QUAD_QPI = 4;
    localparam logic [EDGE_W-1:0] CAND_START [NUM_CAND] = '{5'h14, 5'h0C, 5'h0E, 5'h06, 5'h08};
    localparam logic [EDGE_W-1:0] CAND_DONE [NUM_CAND] = '{5'h18, 5'h10, 5'h10, 5'h08, 5'h0A};
    localparam int CAND_LANES [NUM_CAND] = '{2, 2, 4, 4, 4};

    localparam logic [7:0] MODE_BYTE_RESET = 8'h00;
    localparam logic [7:0] STATUS_DEFAULT = 8'h00;
    localparam logic [7:0] ARRAY_ERASED = 8'hFF;

    localparam real POWER_UP_DELAY_MS = 0.3;
    localparam real REF_CLK_MHZ = 100.0;
    localparam int POWER_UP_CYCLES = int'($ceil(POWER_UP_DELAY_MS * 1000.0 * REF_CLK_MHZ));
endpackage

// >>> design/fmrc_sync.sv
// two-flop level synchroniser
`timescale 1ns/1ns
module fmrc_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    typedef struct packed {
        logic [W-1:0] stage1;
        logic [W-1:0] stage2;
    } fmrc_sync_t;

    fmrc_sync_t st;
    fmrc_sync_t next_st;

    always_comb begin
        next_st.stage1 = d_in;
        next_st.stage2 = st.stage1;
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st <= {INIT, INIT};
        end else begin
            st <= next_st;
        end
    end

    assign q_out = st.stage2;
endmodule

// >>> design/fmrc_top.sv
// mode and reset control of a serial flash command decoder
// Operation
// - capture mode byte of dual/quad I/O reads
// - continuation 10: next frame skips opcode
// - other continuation values: back to opcodes
// - mode byte bits 7:6, 3:0 ignored
// - continuous read ignores ordinary commands
// - release command ends continuous read and QPI
// - QPI entry only when quad enable set
// - QPI switch keeps latch, suspend, wrap
// - QPI exit on release or quad enable clear
// - QPI exit command also ends continuous read
// - no-operation only cancels armed reset
// - in SPI mode no-operation ignores IO lines 3 to 1
// - reset acts only right after reset arm
// - software reset restores power-on defaults
// - other command cancels armed reset
// - reset aborts running program or erase
// - delivery state: array ones, status zeros
`timescale 1ns/1ns
module fmrc_top
    import fmrc_pkg::*;
#(
    parameter int unsigned POWER_UP_CYCLES_P = POWER_UP_CYCLES
) (
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    input wire logic link_clk_in,
    input wire logic cs_n_in,
    input wire logic [3:0] io_in,
    input wire logic quad_enable_in,
    input wire logic busy_in,
    output logic power_up_ready_out,
    output logic qpi_active_out,
    output logic cont_read_out,
    output logic cont_read_quad_out,
    output logic [7:0] mode_byte_out,
    output logic reset_armed_out,
    output logic sw_reset_out,
    output logic abort_out,
    output logic [7:0] status_default_out,
    output logic [7:0] erased_fill_out
);
    localparam int PU_W = $clog2(POWER_UP_CYCLES_P + 1);
    localparam logic [PU_W-1:0] PU_LAST = PU_W'(POWER_UP_CYCLES_P - 1);

    // ---------------- link side, on the serial clock ----------------
    typedef struct packed {
        logic [EDGE_W-1:0] edges;
        logic [7:0] spi_op;
        logic [7:0] qpi_op;
        logic [NUM_CAND-1:0][7:0] cand;
    } fmrc_link_t;

    fmrc_link_t lk;
    fmrc_link_t next_lk;
    logic [EDGE_W-1:0] edge_cnt;
    logic [NUM_CAND-1:0][7:0] cand_nx;

    // the serial clock stops between frames, so the frame's own select clears the count
    always_ff @(posedge link_clk_in or negedge arst_n_in or posedge cs_n_in) begin
        if (!arst_n_in) begin
            edge_cnt <= '0;
        end else if (cs_n_in) begin
            edge_cnt <= '0;
        end else if (edge_cnt != EDGE_MAX) begin
            edge_cnt <= edge_cnt + 5'h01;
        end
    end

    // every position the mode byte can take is captured; the ref side picks by mode
    for (genvar g = 0; g < NUM_CAND; g++) begin : g_cand
        always_comb begin
            cand_nx[g] = lk.cand[g];
            if (edge_cnt >= CAND_START[g] && edge_cnt < CAND_DONE[g]) begin
                if (CAND_LANES[g] == 2) begin
                    cand_nx[g] = {lk.cand[g][5:0], io_in[1:0]};
                end else begin
                    cand_nx[g] = {lk.cand[g][3:0], io_in[3:0]};
                end
            end
        end
    end

    always_comb begin
        next_lk = lk;
        next_lk.edges = (edge_cnt == EDGE_MAX) ? EDGE_MAX : edge_cnt + 5'h01;
        if (edge_cnt < OPC_EDGES_SPI) begin
            // single-bit opcodes come on io0 only; the upper lines are never looked at
            next_lk.spi_op = {lk.spi_op[6:0], io_in[0]};
        end
        if (edge_cnt < OPC_EDGES_QPI) begin
            next_lk.qpi_op = {lk.qpi_op[3:0], io_in[3:0]};
        end
        next_lk.cand = cand_nx;
    end

    always_ff @(posedge link_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            lk <= '0;
        end else begin
            lk <= next_lk;
        end
    end

    // ---------------- control side, on the reference clock ----------------
    typedef struct packed {
        logic cs_d;
        logic ready;
        logic [PU_W-1:0] pu_cnt;
        logic qpi;
        logic cont;
        logic cont_quad;
        logic [7:0] mode_byte;
        logic armed;
        logic sw_reset;
        logic abort;
        logic [7:0] status_default;
        logic [7:0] erased_fill;
    } fmrc_state_t;

    fmrc_state_t st;
    fmrc_state_t next_st;
    logic cs_sync;
    logic frame_end;
    logic [EDGE_W-1:0] opc_len;
    logic [7:0] opcode;
    logic opc_complete;

    fmrc_sync #(
        .W(1),
        .INIT(1'b1)
    ) u_cs_sync (
        .clk_in(ref_clk_in),
        .arst_n_in(arst_n_in),
        .d_in(cs_n_in),
        .q_out(cs_sync)
    );

    // link captures are static once select is high, which is when they are read
    assign frame_end = cs_sync & ~st.cs_d & st.ready;
    assign opc_len = st.qpi ? OPC_EDGES_QPI : OPC_EDGES_SPI;
    assign opcode = st.qpi ? lk.qpi_op : lk.spi_op;
    assign opc_complete = lk.edges >= opc_len;

    always_comb begin
        int idx;
        idx = 0;
        next_st = st;
        next_st.sw_reset = 1'b0;
        next_st.abort = 1'b0;
        next_st.cs_d = cs_sync;
        if (!st.ready) begin
            if (st.pu_cnt == PU_LAST) begin
                next_st.ready = 1'b1;
            end else begin
                next_st.pu_cnt = st.pu_cnt + 1'b1;
            end
        end
        if (frame_end) begin
            if (st.cont) begin
                // only a bare release opcode is seen here: other frames are a read address, so reset commands pass unseen
                if (lk.edges == opc_len && opcode == OP_RELEASE) begin
                    next_st.cont = 1'b0;
                    next_st.qpi = 1'b0;
                end else begin
                    idx = st.cont_quad ? CAND_QUAD_CONT : CAND_DUAL_CONT;
                    if (lk.edges >= CAND_DONE[idx]) begin
                        next_st.mode_byte = lk.cand[idx];
                        // only the continuation field is compared
                        next_st.cont = lk.cand[idx][CONT_FIELD_LSB+:2] == CONT_CODE;
                    end
                end
            end else if (opc_complete) begin
                // any complete command other than the arm drops the armed reset
                next_st.armed = 1'b0;
                case (opcode)
                    OP_RELEASE: begin
                        next_st.qpi = 1'b0;
                        next_st.cont = 1'b0;
                    end
                    OP_QPI_ON: begin
                        // only the interface width flips; latch, suspend and wrap live elsewhere
                        next_st.qpi = st.qpi | quad_enable_in;
                    end
                    OP_DUAL_READ: begin
                        if (!st.qpi && lk.edges >= CAND_DONE[CAND_DUAL_SPI]) begin
                            next_st.mode_byte = lk.cand[CAND_DUAL_SPI];
                            next_st.cont = lk.cand[CAND_DUAL_SPI][CONT_FIELD_LSB+:2] ==
                                CONT_CODE;
                            next_st.cont_quad = 1'b0;
                        end
                    end
                    OP_QUAD_READ: begin
                        idx = st.qpi ? CAND_QUAD_QPI : CAND_QUAD_SPI;
                        if (lk.edges >= CAND_DONE[idx]) begin
                            next_st.mode_byte = lk.cand[idx];
                            next_st.cont = lk.cand[idx][CONT_FIELD_LSB+:2] ==
                                CONT_CODE;
                            next_st.cont_quad = 1'b1;
                        end
                    end
                    OP_RESET_ARM: begin
                        next_st.armed = 1'b1;
                    end
                    OP_NO_OPERATION: begin
                        next_st.armed = 1'b0;
                    end
                    OP_RESET: begin
                        if (st.armed) begin
                            next_st.qpi = 1'b0;
                            next_st.cont = 1'b0;
                            next_st.cont_quad = 1'b0;
                            next_st.mode_byte = MODE_BYTE_RESET;
                            next_st.status_default = STATUS_DEFAULT;
                            next_st.erased_fill = ARRAY_ERASED;
                            next_st.sw_reset = 1'b1;
                            // data under program may be damaged; the array side is told to stop
                            next_st.abort = busy_in;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
        if (!quad_enable_in) begin
            next_st.qpi = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st <= '{cs_d: 1'b1, ready: 1'b0, pu_cnt: '0, qpi: 1'b0, cont: 1'b0,
                    cont_quad: 1'b0, mode_byte: MODE_BYTE_RESET, armed: 1'b0,
                    sw_reset: 1'b0, abort: 1'b0, status_default: STATUS_DEFAULT,
                    erased_fill: ARRAY_ERASED};
        end else begin
            st <= next_st;
        end
    end

    assign power_up_ready_out = st.ready;
    assign qpi_active_out = st.qpi;
    assign cont_read_out = st.cont;
    assign cont_read_quad_out = st.cont_quad;
    assign mode_byte_out = st.mode_byte;
    assign reset_armed_out = st.armed;
    assign sw_reset_out = st.sw_reset;
    assign abort_out = st.abort;
    assign status_default_out = st.status_default;
    assign erased_fill_out = st.erased_fill;

    // ---------------- checks ----------------
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!arst_n_in);

    sequence release_frame_s;
        frame_end && lk.edges == opc_len && opcode == OP_RELEASE;
    endsequence

    sequence armed_reset_s;
        frame_end && !st.cont && opc_complete && opcode == OP_RESET && st.armed;
    endsequence

    sequence qpi_on_frame_s;
        frame_end && !st.cont && opc_complete && opcode == OP_QPI_ON;
    endsequence

    release_exit_a: assert property (
        release_frame_s |=> !cont_read_out && !qpi_active_out)
        else $error("release frame left continuous read or qpi active");
    qpi_gate_a: assert property (
        $rose(qpi_active_out) |->
        $past(frame_end && quad_enable_in && opcode == OP_QPI_ON))
        else $error("qpi entered without enable command and quad enable");
    qe_drop_a: assert property (
        !quad_enable_in |=> !qpi_active_out)
        else $error("qpi stayed active after quad enable cleared");
    reset_pair_a: assert property (
        sw_reset_out |-> $past(reset_armed_out))
        else $error("software reset without armed reset");
    reset_clear_a: assert property (
        armed_reset_s |=> sw_reset_out && !qpi_active_out &&
        !cont_read_out && !reset_armed_out && mode_byte_out == MODE_BYTE_RESET)
        else $error("software reset did not restore defaults");
    arm_cancel_a: assert property (
        frame_end && !st.cont && opc_complete &&
        opcode != OP_RESET_ARM |=> !reset_armed_out)
        else $error("armed reset survived another command");
    abort_link_a: assert property (
        sw_reset_out |-> abort_out == $past(busy_in))
        else $error("abort does not follow busy at reset");
    cont_field_a: assert property (
        cont_read_out |-> mode_byte_out[CONT_FIELD_LSB+:2] == CONT_CODE)
        else $error("continuous read held with wrong continuation field");
    frame_gate_a: assert property (
        $changed(cont_read_out) |-> $past(frame_end))
        else $error("continuous read changed outside frame end");
    cont_blind_a: assert property (
        st.cont && frame_end |=> $stable(reset_armed_out))
        else $error("command decoded during continuous read");
    // the interface width flip must not disturb the read mode state held beside it
    mode_keep_a: assert property (
        qpi_on_frame_s |=> $stable(mode_byte_out) && $stable(cont_read_out))
        else $error("interface switch disturbed read mode state");
    // frames closing before the power-up delay must leave the armed reset and continuous read alone and fire no reset
    early_frame_a: assert property (
        !power_up_ready_out |=> $stable(reset_armed_out) &&
        $stable(cont_read_out) && !sw_reset_out)
        else $error("frame acted on before power-up delay elapsed");
endmodule

// >>> testbench/fmrc_host.sv
// host flash controller model driving chip select, link clock and io lines
`timescale 1ns/1ns
module fmrc_host (
    output logic cs_n_out,
    output logic link_clk_out,
    output logic [3:0] io_out
);
    initial begin
        cs_n_out = 1'b1;
        link_clk_out = 1'b0;
        io_out = 4'h5;
    end
    // link clock stands still between frames; a random start offset keeps its phase
    // unrelated to the ref clock while the period stays at 30 ns
    task automatic frame(input logic [3:0] e[$], input logic [2:0] skew);
        #(1 + skew);
        cs_n_out = 1'b0;
        foreach (e[i]) begin
            io_out = e[i];
            #15 link_clk_out = 1'b1;
            #15 link_clk_out = 1'b0;
        end
        #7;
        cs_n_out = 1'b1;
        // released lines show the inverse of the last value, never a stale copy
        io_out = ~io_out;
    endtask
endmodule

// >>> testbench/fmrc_top_test.sv
// self-checking bench for the flash mode and reset control block
`timescale 1ns/1ns
module fmrc_top_test;
    import fmrc_pkg::*;
    logic ref_clk_in, arst_n_in, link_clk_in, cs_n_in, quad_enable_in, busy_in;
    logic [3:0] io_in;
    logic power_up_ready_out, qpi_active_out, cont_read_out, cont_read_quad_out;
    logic reset_armed_out, sw_reset_out, abort_out;
    logic [7:0] mode_byte_out, status_default_out, erased_fill_out, e_mode, m;
    logic [31:0] rnd;
    logic [3:0] fq[$];
    logic [13:0] exp_q[$];
    logic [13:0] g;
    logic [10:0] last_st;
    logic e_qpi, e_cont, e_quad, e_armed;
    int err_count, checks_done;

    fmrc_top #(.POWER_UP_CYCLES_P(200)) u_dut (.ref_clk_in, .arst_n_in, .link_clk_in,
        .cs_n_in, .io_in, .quad_enable_in, .busy_in, .power_up_ready_out, .qpi_active_out,
        .cont_read_out, .cont_read_quad_out, .mode_byte_out, .reset_armed_out,
        .sw_reset_out, .abort_out, .status_default_out, .erased_fill_out);
    fmrc_host u_host (.cs_n_out(cs_n_in), .link_clk_out(link_clk_in), .io_out(io_in));

    initial begin
        ref_clk_in = 1'b0;
        forever #5 ref_clk_in = ~ref_clk_in;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic wrap_up();
        if (err_count == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic bad(input logic [13:0] gv, input logic [13:0] ev);
        err_count++;
        $display("wrong value at %0t: got %h exp %h", $time, gv, ev);
    endtask

    task automatic check_res(input logic [13:0] gv, input logic [13:0] ev);
        checks_done++;
        // quad flag only means something while continuous read is on
        if (ev[10] !== 1'b1) gv[9] = ev[9];
        if (gv !== ev) bad(gv, ev);
    endtask

    task automatic check_val(input logic [7:0] gv, input logic [7:0] ev);
        checks_done++;
        if (gv !== ev) bad({6'h0, gv}, {6'h0, ev});
    endtask

    // unused io lines carry random levels so the design must ignore them
    task automatic put(input logic [31:0] v, input int nbits, input int lanes);
        logic [3:0] n;
        for (int b = nbits - lanes; b >= 0; b -= lanes) begin
            rnd = lfsr(rnd);
            n = rnd[3:0];
            for (int k = 0; k < lanes; k++)
                n[k] = v[b + k];
            fq.push_back(n);
        end
    endtask

    task automatic cmd(input logic [7:0] c);
        put({24'h0, c}, 8, e_qpi ? 4 : 1);
    endtask

    task automatic send();
        rnd = lfsr(rnd);
        u_host.frame(fq, rnd[2:0]);
        fq.delete();
        repeat (8) @(posedge ref_clk_in);
    endtask

    task automatic fin(input logic s, input logic a);
        exp_q.push_back({s, a, e_qpi, e_cont, e_quad, e_mode, e_armed});
        send();
    endtask

    task automatic setin(input logic qe, input logic bz);
        @(posedge ref_clk_in);
        #1;
        quad_enable_in = qe;
        busy_in = bz;
        repeat (8) @(posedge ref_clk_in);
    endtask

    task automatic quad_rd(input logic [1:0] cf, input logic [3:0] lo, input int ln);
        rnd = lfsr(rnd);
        put(rnd, 24, ln);
        m = {rnd[7:6], cf, lo};
        put({24'h000000, m}, 8, ln);
        e_cont = (cf == CONT_CODE);
        e_quad = (ln == 4);
        e_mode = m;
    endtask

    always @(posedge ref_clk_in) begin
        #1;
        g = {sw_reset_out, abort_out, qpi_active_out, cont_read_out, cont_read_quad_out,
            mode_byte_out, reset_armed_out};
        if (arst_n_in === 1'b1 && (g[13] !== 1'b0 || {g[11:10], g[8:0]} !== last_st)) begin
            if (exp_q.size() == 0) bad(g, 14'h3FFF);
            else check_res(g, exp_q.pop_front());
        end
        last_st = {g[11:10], g[8:0]};
    end

    initial begin
        repeat (50000) @(posedge ref_clk_in);
        err_count++;
        wrap_up();
    end

    initial begin
        arst_n_in = 1'b0;
        quad_enable_in = 1'b0;
        busy_in = 1'b0;
        rnd = 32'hA859;
        {e_qpi, e_cont, e_quad, e_armed, e_mode} = 12'h000;
        repeat (10) @(posedge ref_clk_in);
        #1 arst_n_in = 1'b1;
        check_val(status_default_out, STATUS_DEFAULT);
        check_val(erased_fill_out, ARRAY_ERASED);
        check_val({7'h00, power_up_ready_out}, 8'h00);
        // frame ending before the power-up delay must be dropped
        cmd(OP_RESET_ARM);
        send();
        for (int i = 0; i < 400 && power_up_ready_out !== 1'b1; i++)
            @(posedge ref_clk_in);
        if (power_up_ready_out !== 1'b1) begin
            err_count++;
            wrap_up();
        end
        cmd(OP_RELEASE);
        send();
        cmd(OP_QPI_ON);
        send();
        setin(1'b1, 1'b0);
        cmd(OP_QPI_ON);
        e_qpi = 1'b1;
        fin(1'b0, 1'b0);
        put(32'hF, 4, 4);
        send();
        cmd(OP_RELEASE);
        e_qpi = 1'b0;
        fin(1'b0, 1'b0);
        cmd(OP_QPI_ON);
        e_qpi = 1'b1;
        fin(1'b0, 1'b0);
        e_qpi = 1'b0;
        exp_q.push_back({2'b00, e_qpi, e_cont, e_quad, e_mode, e_armed});
        setin(1'b0, 1'b0);
        setin(1'b1, 1'b0);
        cmd(OP_QUAD_READ);
        quad_rd(2'b10, 4'hA, 4);
        fin(1'b0, 1'b0);
        for (int i = 0; i < 3; i++) begin
            quad_rd(2'b10, 4'(i), 4);
            fin(1'b0, 1'b0);
        end
        // reset-arm pattern on the lines is only an address while reading continuously
        put(32'h666666, 24, 4);
        put({24'h000000, e_mode}, 8, 4);
        send();
        // low nibble keeps io0 from being all ones, which would read as a release frame
        quad_rd(2'b11, 4'h4, 4);
        fin(1'b0, 1'b0);
        cmd(OP_QUAD_READ);
        quad_rd(2'b10, 4'hC, 4);
        fin(1'b0, 1'b0);
        cmd(OP_RELEASE);
        e_cont = 1'b0;
        fin(1'b0, 1'b0);
        cmd(OP_DUAL_READ);
        quad_rd(2'b10, 4'h3, 2);
        fin(1'b0, 1'b0);
        quad_rd(2'b10, 4'h9, 2);
        fin(1'b0, 1'b0);
        quad_rd(2'b00, 4'h1, 2);
        fin(1'b0, 1'b0);
        cmd(OP_QPI_ON);
        e_qpi = 1'b1;
        fin(1'b0, 1'b0);
        cmd(OP_QUAD_READ);
        quad_rd(2'b10, 4'h7, 4);
        fin(1'b0, 1'b0);
        cmd(OP_RELEASE);
        {e_qpi, e_cont} = 2'b00;
        fin(1'b0, 1'b0);
        cmd(OP_RESET_ARM);
        e_armed = 1'b1;
        fin(1'b0, 1'b0);
        cmd(OP_NO_OPERATION);
        e_armed = 1'b0;
        fin(1'b0, 1'b0);
        cmd(OP_RESET_ARM);
        e_armed = 1'b1;
        fin(1'b0, 1'b0);
        setin(1'b0, 1'b0);
        cmd(OP_QPI_ON);
        e_armed = 1'b0;
        fin(1'b0, 1'b0);
        cmd(OP_RESET);
        send();
        setin(1'b1, 1'b1);
        cmd(OP_QPI_ON);
        e_qpi = 1'b1;
        fin(1'b0, 1'b0);
        cmd(OP_RESET_ARM);
        e_armed = 1'b1;
        fin(1'b0, 1'b0);
        cmd(OP_RESET);
        {e_qpi, e_cont, e_armed, e_mode} = 11'h000;
        fin(1'b1, 1'b1);
        setin(1'b1, 1'b0);
        cmd(OP_RESET_ARM);
        e_armed = 1'b1;
        fin(1'b0, 1'b0);
        cmd(OP_RESET);
        e_armed = 1'b0;
        fin(1'b1, 1'b0);
        repeat (20) @(posedge ref_clk_in);
        check_val(status_default_out, STATUS_DEFAULT);
        check_val(erased_fill_out, ARRAY_ERASED);
        if (exp_q.size() != 0) bad(14'h0, exp_q[0]);
        wrap_up();
    end
endmodule
